// ==== verilog/rivm_pkg.sv ====
// Package: constants and carrier types for the reset and interrupt vector map
package rivm_pkg;

  // Widths: word address covers the largest variant's program memory
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned VEC_W = 5;
  localparam int unsigned NUM_IRQ = 26;

  // Strap codes presented on the variant input
  localparam logic [1:0] VARIANT_SMALL_CODE = 2'h0;
  localparam logic [1:0] VARIANT_MID_CODE = 2'h1;
  localparam logic [1:0] VARIANT_LARGE_CODE = 2'h2;

  // Fuse polarity: a stored 0 means programmed
  localparam logic FUSE_PROGRAMMED = 1'h0;

  // Application start and the step between entries, as a shift of the table offset
  localparam logic [ADDR_W-1:0] APP_START_ADDR = 13'h0000;
  localparam int unsigned STEP_SHIFT_NARROW = 0;
  localparam int unsigned STEP_SHIFT_WIDE = 1;

  // Vector number of an entry is its table offset plus this
  localparam logic [VEC_W-1:0] VECNO_BIAS = 5'h01;

  // Table offsets, one entry per vector: one instruction word, two on the largest variant
  localparam logic [VEC_W-1:0] TBL_RESET = 5'h00;
  localparam logic [VEC_W-1:0] TBL_EXT_IRQ_ZERO = 5'h01;
  localparam logic [VEC_W-1:0] TBL_EXT_IRQ_ONE = 5'h02;
  localparam logic [VEC_W-1:0] TBL_PIN_CHANGE_GROUP_ZERO = 5'h03;
  localparam logic [VEC_W-1:0] TBL_PIN_CHANGE_GROUP_ONE = 5'h04;
  localparam logic [VEC_W-1:0] TBL_PIN_CHANGE_GROUP_TWO = 5'h05;
  localparam logic [VEC_W-1:0] TBL_WATCHDOG_TIMEOUT = 5'h06;
  localparam logic [VEC_W-1:0] TBL_TMR2_CMP_A = 5'h07;
  localparam logic [VEC_W-1:0] TBL_TMR2_CMP_B = 5'h08;
  localparam logic [VEC_W-1:0] TBL_TMR2_OVERFLOW = 5'h09;
  localparam logic [VEC_W-1:0] TBL_TMR1_CAPTURE = 5'h0a;
  localparam logic [VEC_W-1:0] TBL_TMR1_CMP_A = 5'h0b;
  localparam logic [VEC_W-1:0] TBL_TMR1_CMP_B = 5'h0c;
  localparam logic [VEC_W-1:0] TBL_TMR1_OVERFLOW = 5'h0d;
  localparam logic [VEC_W-1:0] TBL_TMR0_CMP_A = 5'h0e;
  localparam logic [VEC_W-1:0] TBL_TMR0_CMP_B = 5'h0f;
  localparam logic [VEC_W-1:0] TBL_TMR0_OVERFLOW = 5'h10;
  localparam logic [VEC_W-1:0] TBL_SERIAL_XFER_DONE = 5'h11;
  localparam logic [VEC_W-1:0] TBL_UART_RX_DONE = 5'h12;
  localparam logic [VEC_W-1:0] TBL_TX_BUFFER_EMPTY = 5'h13;
  localparam logic [VEC_W-1:0] TBL_UART_TX_DONE = 5'h14;
  localparam logic [VEC_W-1:0] TBL_CONVERSION_DONE = 5'h15;
  localparam logic [VEC_W-1:0] TBL_EEPROM_READY_EVENT = 5'h16;
  localparam logic [VEC_W-1:0] TBL_COMPARATOR_EVENT = 5'h17;
  localparam logic [VEC_W-1:0] TBL_TWO_WIRE_SERIAL_PORT = 5'h18;
  localparam logic [VEC_W-1:0] TBL_FLASH_SELF_WRITE_READY = 5'h19;
  localparam logic [VEC_W-1:0] TBL_UART_START_EDGE = 5'h1a;

  // Device variant after decoding the strap
  typedef enum logic [1:0] {
    RIVM_VAR_SMALL,
    RIVM_VAR_MID,
    RIVM_VAR_LARGE
  } rivm_variant_e;

  // Request lines; first field is the most significant bit, so bit 0 is ext_irq_zero
  typedef struct packed {
    logic uart_start_edge;
    logic flash_self_write_ready;
    logic two_wire_serial_port;
    logic comparator_event;
    logic eeprom_ready_event;
    logic conversion_done;
    logic uart_tx_done;
    logic tx_buffer_empty;
    logic uart_rx_done;
    logic serial_xfer_done;
    logic tmr0_overflow;
    logic tmr0_cmp_b;
    logic tmr0_cmp_a;
    logic tmr1_overflow;
    logic tmr1_cmp_b;
    logic tmr1_cmp_a;
    logic tmr1_capture;
    logic tmr2_overflow;
    logic tmr2_cmp_b;
    logic tmr2_cmp_a;
    logic watchdog_timeout;
    logic pin_change_group_two;
    logic pin_change_group_one;
    logic pin_change_group_zero;
    logic ext_irq_one;
    logic ext_irq_zero;
  } rivm_irq_req_s;

  // A vector handed to the fetch logic
  typedef struct packed {
    logic [VEC_W-1:0] vecno;
    logic [ADDR_W-1:0] addr;
  } rivm_vector_s;

endpackage

// ==== verilog/rivm_prio_enc.sv ====
// Fixed-priority encoder: lowest request index wins
`timescale 1ns/1ps
module rivm_prio_enc
  import rivm_pkg::*;
(
  input wire logic [NUM_IRQ-1:0] req_i,
  output logic valid_o,
  output logic [VEC_W-1:0] idx_o
);

  // Scan downward so the lowest set bit is the last one written
  always_comb begin
    valid_o = 1'b0;
    idx_o = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        valid_o = 1'b1;
        idx_o = VEC_W'(i);
      end
    end
  end

endmodule

// ==== verilog/rivm_addr_gen.sv ====
// Program address of a vector entry from its table offset, variant and base
`timescale 1ns/1ps
module rivm_addr_gen
  import rivm_pkg::*;
(
  input wire rivm_variant_e variant_i,
  input wire logic boot_sel_i,
  input wire logic [ADDR_W-1:0] boot_start_i,
  input wire logic [VEC_W-1:0] tbl_off_i,
  output logic [ADDR_W-1:0] addr_o
);

  // Entry spacing: two words on the largest variant, one otherwise
  function automatic logic [ADDR_W-1:0] entry_offset(input rivm_variant_e v,
                                                     input logic [VEC_W-1:0] off);
    logic [ADDR_W-1:0] wide;
    wide = ADDR_W'(off);
    if (v == RIVM_VAR_LARGE) begin
      entry_offset = wide << STEP_SHIFT_WIDE;
    end else begin
      entry_offset = wide << STEP_SHIFT_NARROW;
    end
  endfunction

  // The smallest part has no boot section, so its base never moves
  wire logic relocate = boot_sel_i && (variant_i != RIVM_VAR_SMALL);
  wire logic [ADDR_W-1:0] base = relocate ? boot_start_i : APP_START_ADDR;

  assign addr_o = ADDR_W'(base + entry_offset(variant_i, tbl_off_i));

endmodule

// ==== verilog/rivm_vector_map.sv ====
// Reset and interrupt vector map: picks, numbers and places every vector
//
// Contract
// R1: Entry spans two words on largest variant
// R2: Smallest variant never relocates reset or table
// R3: Larger variants: fuse picks reset start address
// R4: Larger variants: select bit picks table base
// R5: All resets take vector 1 at 0x000
// R6: External requests zero, one at 0x001, 0x002
// R7: Pin-change groups at 0x003 through 0x005
// R8: Watchdog timeout is vector 7 at 0x006
// R9: Timer2 compare A, B, overflow at 0x007-0x009
// R10: Timer1 capture, compare A, B, overflow 0x00A-0x00D
// R11: Timer0 compare A, B, overflow at 0x00E-0x010
// R12: Serial transfer complete at 0x011
// R13: Uart receive, buffer empty, transmit 0x012-0x014
// R14: Conversion, eeprom ready, comparator at 0x015-0x017
// R15: Two-wire port 0x018, self-write ready 0x019
// R16: Uart start edge is vector 27 at 0x01A
// R17: Select bit set adds boot start to vectors
// R18: Programmed fuse starts execution at boot address
// R19: Fuse stored 1 unprogrammed, 0 programmed
// R20: Lowest vector number pending is served first
`timescale 1ns/1ps
module rivm_vector_map
  import rivm_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic [1:0] VARIANT_I,
  input wire logic BOOT_RESET_SELECT_FUSE_I,
  input wire logic [ADDR_W-1:0] BOOT_START_I,
  input wire logic VECTOR_TABLE_SELECT_I,
  input wire rivm_irq_req_s IRQ_REQ_I,
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic RESET_TAKEN_I,
  input wire logic IRQ_ACK_I,
  output logic RESET_VALID_O,
  output rivm_vector_s RESET_VECTOR_O,
  output logic IRQ_VALID_O,
  output rivm_vector_s IRQ_VECTOR_O,
  output logic [NUM_IRQ-1:0] IRQ_CLEAR_O,
  output logic [NUM_IRQ-1:0] PENDING_O,
  output logic BOOT_RESET_ACTIVE_O,
  output logic VECTORS_IN_BOOT_O
);

  typedef enum logic [1:0] {
    ST_CAPTURE,
    ST_RESET,
    ST_IDLE,
    ST_IRQ
  } rivm_state_e;

  // Table offset of each request line, indexed like the request struct
  localparam logic [VEC_W-1:0] IRQ_TBL [NUM_IRQ] = '{
    TBL_EXT_IRQ_ZERO, // [R6]
    TBL_EXT_IRQ_ONE, // [R6]
    TBL_PIN_CHANGE_GROUP_ZERO, // [R7]
    TBL_PIN_CHANGE_GROUP_ONE, // [R7]
    TBL_PIN_CHANGE_GROUP_TWO, // [R7]
    TBL_WATCHDOG_TIMEOUT, // [R8]
    TBL_TMR2_CMP_A, // [R9]
    TBL_TMR2_CMP_B, // [R9]
    TBL_TMR2_OVERFLOW, // [R9]
    TBL_TMR1_CAPTURE, // [R10]
    TBL_TMR1_CMP_A, // [R10]
    TBL_TMR1_CMP_B, // [R10]
    TBL_TMR1_OVERFLOW, // [R10]
    TBL_TMR0_CMP_A, // [R11]
    TBL_TMR0_CMP_B, // [R11]
    TBL_TMR0_OVERFLOW, // [R11]
    TBL_SERIAL_XFER_DONE, // [R12]
    TBL_UART_RX_DONE, // [R13]
    TBL_TX_BUFFER_EMPTY, // [R13]
    TBL_UART_TX_DONE, // [R13]
    TBL_CONVERSION_DONE, // [R14]
    TBL_EEPROM_READY_EVENT, // [R14]
    TBL_COMPARATOR_EVENT, // [R14]
    TBL_TWO_WIRE_SERIAL_PORT, // [R15]
    TBL_FLASH_SELF_WRITE_READY, // [R15]
    TBL_UART_START_EDGE // [R16]
  };

  // Strap decode; an unknown code is treated as the smallest, never relocating part
  function automatic rivm_variant_e decode_variant(input logic [1:0] code);
    if (code == VARIANT_LARGE_CODE) begin
      decode_variant = RIVM_VAR_LARGE;
    end else if (code == VARIANT_MID_CODE) begin
      decode_variant = RIVM_VAR_MID;
    end else begin
      decode_variant = RIVM_VAR_SMALL;
    end
  endfunction

  rivm_state_e state_reg;
  rivm_state_e state_next;
  rivm_variant_e variant_reg;
  logic fuse_prog_reg;
  logic [ADDR_W-1:0] boot_start_reg;
  logic [NUM_IRQ-1:0] pending_reg;
  logic [NUM_IRQ-1:0] pending_next;
  logic [VEC_W-1:0] sel_idx_reg;
  rivm_vector_s reset_vec_reg;
  rivm_vector_s irq_vec_reg;
  logic [NUM_IRQ-1:0] clear_onehot;

  wire logic [NUM_IRQ-1:0] req_flat = IRQ_REQ_I;
  wire logic win_valid;
  wire logic [VEC_W-1:0] win_idx;
  wire logic [VEC_W-1:0] win_tbl = IRQ_TBL[win_idx];
  wire logic [ADDR_W-1:0] win_addr;
  wire logic [ADDR_W-1:0] reset_addr;

  // Fuse polarity: only a stored 0 counts as programmed
  wire logic fuse_prog_now = (BOOT_RESET_SELECT_FUSE_I == FUSE_PROGRAMMED); // [R19]
  wire rivm_variant_e variant_now = decode_variant(VARIANT_I);

  // Handshake terms
  wire logic reset_done = (state_reg == ST_RESET) && RESET_TAKEN_I;
  wire logic irq_done = (state_reg == ST_IRQ) && IRQ_ACK_I;
  wire logic irq_start = (state_reg == ST_IDLE) && GLOBAL_IRQ_EN_I && win_valid;

  // Lowest pending index wins
  rivm_prio_enc u_prio (
    .req_i(pending_reg),
    .valid_o(win_valid),
    .idx_o(win_idx)
  ); // [R20]

  // Reset start: every reset source lands on table offset zero, moved only by the fuse.
  // Fed from the live straps so the vector is right in the very cycle they are caught.
  rivm_addr_gen u_reset_addr (
    .variant_i(variant_now),
    .boot_sel_i(fuse_prog_now), // [R3] [R18]
    .boot_start_i(BOOT_START_I),
    .tbl_off_i(TBL_RESET), // [R5]
    .addr_o(reset_addr)
  ); // [R1] [R2]

  // Interrupt entry: base follows the live table-select bit
  rivm_addr_gen u_irq_addr (
    .variant_i(variant_reg),
    .boot_sel_i(VECTOR_TABLE_SELECT_I), // [R4] [R17]
    .boot_start_i(boot_start_reg),
    .tbl_off_i(win_tbl),
    .addr_o(win_addr)
  ); // [R1] [R2]

  // One-hot clear for the source being acknowledged
  always_comb begin
    clear_onehot = '0;
    clear_onehot[sel_idx_reg] = 1'b1;
  end

  // Pending flags: a request arriving in the acknowledge cycle is kept, set beats clear
  always_comb begin
    pending_next = pending_reg;
    if (irq_done) begin
      pending_next = pending_next & ~clear_onehot;
    end
    pending_next = pending_next | req_flat;
  end

  // Sequencer: capture straps, hand out reset vector, then serve interrupts
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CAPTURE: begin
        state_next = ST_RESET;
      end
      ST_RESET: begin
        if (reset_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_start) begin
          state_next = ST_IRQ;
        end
      end
      ST_IRQ: begin
        if (irq_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_CAPTURE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= ST_CAPTURE;
    end else if (CE_I) begin
      state_reg <= state_next;
    end
  end

  // Straps are caught after release, not under the asynchronous reset
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      variant_reg <= RIVM_VAR_SMALL;
      fuse_prog_reg <= 1'b0;
      boot_start_reg <= APP_START_ADDR;
    end else if (CE_I && (state_reg == ST_CAPTURE)) begin
      variant_reg <= variant_now;
      fuse_prog_reg <= fuse_prog_now; // [R19]
      boot_start_reg <= BOOT_START_I;
    end
  end

  // Reset vector is caught together with the straps, then held for the whole offer
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      reset_vec_reg <= '0;
    end else if (CE_I && (state_reg == ST_CAPTURE)) begin
      reset_vec_reg.vecno <= VEC_W'(TBL_RESET + VECNO_BIAS); // [R5]
      reset_vec_reg.addr <= reset_addr; // [R3] [R18]
    end
  end

  // Pending flags
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pending_reg <= '0;
    end else if (CE_I) begin
      pending_reg <= pending_next;
    end
  end

  // Winner is frozen while the core works on it, so later arrivals cannot swap it
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sel_idx_reg <= '0;
      irq_vec_reg <= '0;
    end else if (CE_I && irq_start) begin
      sel_idx_reg <= win_idx; // [R20]
      irq_vec_reg.vecno <= VEC_W'(win_tbl + VECNO_BIAS); // [R8] [R16]
      irq_vec_reg.addr <= win_addr; // [R17]
    end
  end

  // Outputs; the reset vector is only offered once it is registered
  assign RESET_VALID_O = (state_reg == ST_RESET);
  assign RESET_VECTOR_O = reset_vec_reg;
  assign IRQ_VALID_O = (state_reg == ST_IRQ);
  assign IRQ_VECTOR_O = irq_vec_reg;
  assign IRQ_CLEAR_O = (irq_done && CE_I) ? clear_onehot : '0;
  assign PENDING_O = pending_reg;
  assign BOOT_RESET_ACTIVE_O = fuse_prog_reg && (variant_reg != RIVM_VAR_SMALL); // [R2]
  assign VECTORS_IN_BOOT_O = VECTOR_TABLE_SELECT_I && (variant_reg != RIVM_VAR_SMALL); // [R2]

endmodule

// ==== tb/rivm_vector_map_assertions.sv ====
// Checker for the vector map outputs, bound to the top module
`timescale 1ns/1ps
module rivm_vector_map_checker
  import rivm_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic [1:0] VARIANT_I,
  input wire logic BOOT_RESET_SELECT_FUSE_I,
  input wire logic [ADDR_W-1:0] BOOT_START_I,
  input wire logic VECTOR_TABLE_SELECT_I,
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic RESET_TAKEN_I,
  input wire logic IRQ_ACK_I,
  input wire logic RESET_VALID_O,
  input wire rivm_vector_s RESET_VECTOR_O,
  input wire logic IRQ_VALID_O,
  input wire rivm_vector_s IRQ_VECTOR_O,
  input wire logic [NUM_IRQ-1:0] IRQ_CLEAR_O,
  input wire logic [NUM_IRQ-1:0] PENDING_O,
  input wire logic BOOT_RESET_ACTIVE_O,
  input wire logic VECTORS_IN_BOOT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic ext;
  logic [ADDR_W-1:0] off;
  logic sel_seen;
  logic [4:0] low_next;
  logic [4:0] low_reg;
  // Variants that own a boot section, and the expected entry placement
  assign ext = VARIANT_I == VARIANT_MID_CODE || VARIANT_I == VARIANT_LARGE_CODE;
  assign off = ADDR_W'(IRQ_VECTOR_O.vecno - VECNO_BIAS);
  // Table placement as seen at the selection edge; the vector is frozen from there on
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) sel_seen <= 1'b0;
    else if (!IRQ_VALID_O) sel_seen <= VECTORS_IN_BOOT_O;
  end
  // Lowest pending index, remembered across the selection edge
  always_comb begin
    low_next = 5'h1f;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (PENDING_O[i]) low_next = 5'(i);
    end
  end
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) low_reg <= 5'h1f;
    else low_reg <= low_next;
  end
  rst_vecno_a: assert property (RESET_VALID_O |-> RESET_VECTOR_O.vecno == 5'h01)
    else $error("reset vector number wrong");
  rst_addr_a: assert property (RESET_VALID_O |-> RESET_VECTOR_O.addr ==
    (BOOT_RESET_ACTIVE_O ? BOOT_START_I : APP_START_ADDR)) else $error("reset address wrong");
  fuse_pol_a: assert property (RESET_VALID_O |->
    BOOT_RESET_ACTIVE_O == (ext && BOOT_RESET_SELECT_FUSE_I == 1'h0)) else $error("fuse decode");
  tbl_base_a: assert property (RESET_VALID_O || IRQ_VALID_O |->
    VECTORS_IN_BOOT_O == (ext && VECTOR_TABLE_SELECT_I)) else $error("table base select");
  irq_addr_a: assert property (IRQ_VALID_O |-> IRQ_VECTOR_O.addr ==
    (sel_seen ? BOOT_START_I : APP_START_ADDR) +
    (VARIANT_I == VARIANT_LARGE_CODE ? off << 1 : off)) else $error("vector address wrong");
  prio_pick_a: assert property ($rose(IRQ_VALID_O) |->
    IRQ_VECTOR_O.vecno == low_reg + 5'h02) else $error("priority order wrong");
  clr_onehot_a: assert property (IRQ_VALID_O && IRQ_ACK_I && CE_I |->
    IRQ_CLEAR_O == NUM_IRQ'(1) << (IRQ_VECTOR_O.vecno - 5'h02)) else $error("clear pulse");
  ack_drop_a: assert property (IRQ_VALID_O && IRQ_ACK_I && CE_I |=> !IRQ_VALID_O)
    else $error("valid held after ack");
  taken_drop_a: assert property (RESET_VALID_O && RESET_TAKEN_I && CE_I |=> !RESET_VALID_O)
    else $error("reset valid held");
  hold_off_a: assert property (!GLOBAL_IRQ_EN_I && !IRQ_VALID_O |=> !IRQ_VALID_O)
    else $error("served while disabled");
  vec_hold_a: assert property (IRQ_VALID_O && !IRQ_ACK_I |=>
    IRQ_VALID_O && $stable(IRQ_VECTOR_O)) else $error("vector not held");
  cover property (RESET_VALID_O && BOOT_RESET_ACTIVE_O);
  cover property (IRQ_VALID_O && VECTORS_IN_BOOT_O && VARIANT_I == VARIANT_LARGE_CODE);
  cover property ($rose(IRQ_VALID_O) && $countones(PENDING_O) > 1);
endmodule

bind rivm_vector_map rivm_vector_map_checker chk_u (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .CE_I(CE_I), .VARIANT_I(VARIANT_I), .BOOT_RESET_SELECT_FUSE_I(BOOT_RESET_SELECT_FUSE_I),
  .BOOT_START_I(BOOT_START_I), .VECTOR_TABLE_SELECT_I(VECTOR_TABLE_SELECT_I),
  .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .RESET_TAKEN_I(RESET_TAKEN_I), .IRQ_ACK_I(IRQ_ACK_I),
  .RESET_VALID_O(RESET_VALID_O), .RESET_VECTOR_O(RESET_VECTOR_O), .IRQ_VALID_O(IRQ_VALID_O),
  .IRQ_VECTOR_O(IRQ_VECTOR_O), .IRQ_CLEAR_O(IRQ_CLEAR_O), .PENDING_O(PENDING_O),
  .BOOT_RESET_ACTIVE_O(BOOT_RESET_ACTIVE_O), .VECTORS_IN_BOOT_O(VECTORS_IN_BOOT_O));

// ==== tb/rivm_core_model.sv ====
// Model of the core fetch logic: takes the reset vector, acknowledges interrupts
`timescale 1ns/1ps
module rivm_core_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic reset_valid_i,
  input wire logic irq_valid_i,
  input wire logic [1:0] delay_i,
  output logic reset_taken_o,
  output logic irq_ack_o
);
  logic [1:0] wait_reg;
  // Falling-edge drive keeps requests settled at the sampling edge; slow acks stretch valid
  always @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reset_taken_o <= 1'b0;
      irq_ack_o <= 1'b0;
      wait_reg <= 2'h0;
    end else begin
      reset_taken_o <= reset_valid_i;
      irq_ack_o <= irq_valid_i && wait_reg >= delay_i && !irq_ack_o;
      if (!irq_valid_i) wait_reg <= 2'h0;
      else if (wait_reg != 2'h3) wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking testbench for the reset and interrupt vector map
`timescale 1ns/1ps
module tb_top;
  import rivm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] variant = VARIANT_MID_CODE;
  logic fuse = 1'h1;
  logic sel = 1'h0;
  logic gen = 1'h1;
  logic [ADDR_W-1:0] boot = 13'h0c00;
  rivm_irq_req_s req = '0;
  logic [1:0] dly = 2'h0;
  logic ce = 1'b1;
  logic [NUM_IRQ-1:0] clr;
  logic rst_taken, ack, rst_valid, irq_valid, boot_act, in_boot;
  rivm_vector_s rst_vec, irq_vec;
  logic [NUM_IRQ-1:0] pend;
  int miscompares = 0;
  int check_count = 0;

  always #5 clk = ~clk;

  rivm_vector_map dut_u (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .VARIANT_I(variant),
    .BOOT_RESET_SELECT_FUSE_I(fuse), .BOOT_START_I(boot), .VECTOR_TABLE_SELECT_I(sel),
    .IRQ_REQ_I(req), .GLOBAL_IRQ_EN_I(gen), .RESET_TAKEN_I(rst_taken), .IRQ_ACK_I(ack),
    .RESET_VALID_O(rst_valid), .RESET_VECTOR_O(rst_vec), .IRQ_VALID_O(irq_valid),
    .IRQ_VECTOR_O(irq_vec), .IRQ_CLEAR_O(clr), .PENDING_O(pend),
    .BOOT_RESET_ACTIVE_O(boot_act), .VECTORS_IN_BOOT_O(in_boot));

  rivm_core_model core_u (.clk_i(clk), .nrst_i(nrst), .reset_valid_i(rst_valid),
    .irq_valid_i(irq_valid), .delay_i(dly), .reset_taken_o(rst_taken), .irq_ack_o(ack));

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_vec(input rivm_vector_s got, input rivm_vector_s exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flags(input logic [NUM_IRQ-1:0] got, input logic [NUM_IRQ-1:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for a valid flag to reach a level; a hang ends the run
  task automatic wait_lvl(input bit irq, input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        miscompares++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, ~lvl, lvl);
        finish_test();
      end
    end while ((irq ? irq_valid : rst_valid) !== lvl);
  endtask

  task automatic do_rst(input logic [1:0] v, input logic f, input logic s);
    nrst = 1'b0;
    variant = v;
    fuse = f;
    sel = s;
    req = '0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    wait_lvl(1'b0, 1'b1);
  endtask

  // Expected vector of request bit k: table slot k+1, doubled on the large variant
  function automatic rivm_vector_s exp_irq(input int k, input logic reloc, input logic wide);
    logic [ADDR_W-1:0] o;
    o = ADDR_W'(k + 1);
    return {VEC_W'(k + 2), (reloc ? boot : 13'h0000) + (wide ? o << 1 : o)};
  endfunction

  task automatic one_irq(input int k, input logic reloc, input logic wide);
    @(negedge clk);
    req = rivm_irq_req_s'(NUM_IRQ'(1) << k);
    @(negedge clk);
    req = '0;
    wait_lvl(1'b1, 1'b1);
    cmp_vec(irq_vec, exp_irq(k, reloc, wide));
    // Acknowledge is up shortly after this edge; the clear pulse names the served source
    #2;
    cmp_flags(clr, NUM_IRQ'(1) << k);
  endtask

  task automatic t_reset;
    logic bt;
    // Code 3 is unassigned and must behave like the smallest part
    for (int v = 0; v < 4; v++) begin
      for (int f = 0; f < 2; f++) begin
        do_rst(v[1:0], f[0], 1'b1);
        bt = (v[1:0] == VARIANT_MID_CODE || v[1:0] == VARIANT_LARGE_CODE) && f == 0;
        cmp_vec(rst_vec, {5'h01, bt ? boot : 13'h0000});
        cmp_flags(NUM_IRQ'(boot_act), NUM_IRQ'(bt));
      end
    end
    $display("test reset_map done");
  endtask

  task automatic t_table;
    do_rst(VARIANT_MID_CODE, 1'h1, 1'h0);
    for (int k = 0; k < NUM_IRQ; k++) begin
      one_irq(k, 1'b0, 1'b0);
    end
    $display("test table done");
  endtask

  task automatic t_wide;
    do_rst(VARIANT_LARGE_CODE, 1'h1, 1'h1);
    cmp_flags(NUM_IRQ'(in_boot), NUM_IRQ'(1));
    one_irq(0, 1'b1, 1'b1);
    one_irq(25, 1'b1, 1'b1);
    sel = 1'h0;
    one_irq(12, 1'b0, 1'b1);
    do_rst(VARIANT_SMALL_CODE, 1'h0, 1'h1);
    one_irq(25, 1'b0, 1'b0);
    $display("test wide_relocate done");
  endtask

  // Three requests pile up while disabled, then come out lowest first, slowly acked
  task automatic t_prio;
    int order [3] = '{3, 12, 25};
    do_rst(VARIANT_MID_CODE, 1'h1, 1'h0);
    gen = 1'b0;
    dly = 2'h3;
    @(negedge clk);
    req = rivm_irq_req_s'(26'h2001008);
    @(negedge clk);
    req = '0;
    repeat (3) @(negedge clk);
    cmp_flags(pend, 26'h2001008);
    cmp_flags(NUM_IRQ'(irq_valid), 26'h0);
    // Enable low freezes the sequencer even with requests pending and serving allowed
    ce = 1'b0;
    gen = 1'b1;
    repeat (3) @(negedge clk);
    cmp_flags(NUM_IRQ'(irq_valid), 26'h0);
    ce = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_lvl(1'b1, 1'b1);
      cmp_vec(irq_vec, exp_irq(order[i], 1'b0, 1'b0));
      wait_lvl(1'b1, 1'b0);
    end
    $display("test priority done");
  endtask

  initial begin
    t_reset();
    t_table();
    t_wide();
    t_prio();
    finish_test();
  end
endmodule
